// ==== hw/dcr_channel_config.v ====
// Function
// R1: NO_OPERATION_WORD register reads zero, no side effects
// R2: NO_OPERATION_WORD at PMBus page FFh, command D0h
// R3: Margin-high at 25h; page 03h ch0, 00h ch1
// R4: Margin-low at 26h; page 03h ch0, 00h ch1
// R5: Gain/comparator setup at FFh, DDh ch0, D1h ch1
// R6: Margin-high code in bits 15..4, unsigned
// R7: Margin-low code in bits 15..4, left aligned
// R8: Ten-bit variant drops two lowest code bits
// R9: Bits 12..10 select gain and reference
// R10: Bit 4 open-drain only with comparator routed
// R11: Bit 3 routes comparator result to pin
// R12: Bit 2 connects feedback input to divider
// R13: Bit 1 inverts comparator output polarity
// R14: Bit 0 enables comparator mode
// R15: Host powers down current output first
// R16: Margin and setup registers reset to zero
// R17: Don't-care bits read zero; bad gain ignored
`timescale 1ns/1ns
`include "dcr_regs.vh"

module dcr_channel_config #(
  parameter TEN_BIT = 0
) (
  input  wire        ref_clk,
  input  wire        arst_n,
  input  wire        regWrite,
  input  wire        regRead,
  input  wire        pmbusSel,
  input  wire [7:0]  regAddr,
  input  wire [7:0]  pmbusPage,
  input  wire [15:0] regWData,
  input  wire [1:0]  cmpRaw,
  output reg  [15:0] regRData,
  output reg         regRValid,
  output reg         regHit,
  output wire [23:0] marginHigh,
  output wire [23:0] marginLow,
  output wire [5:0]  gainSelect,
  output wire [1:0]  comparatorModeEnable,
  output wire [1:0]  comparatorPinRoute,
  output wire [1:0]  comparatorOpendrainEnable,
  output wire [1:0]  feedbackDividerConnect,
  output wire [1:0]  comparatorPolarityInvert,
  output wire [1:0]  cmpResult,
  output wire [1:0]  cmpPinActive,
  output wire [1:0]  channelOutputPinOut,
  output wire [1:0]  channelOutputPinOe
);

  wire [15:0] mhiWord [0:1];
  wire [15:0] mloWord [0:1];
  wire [15:0] cfgWord [0:1];
  wire [1:0]  selMhi;
  wire [1:0]  selMlo;
  wire [1:0]  selCfg;
  wire        selNop;

  // Both address schemes decode to the same storage
  assign selNop = pmbusSel ?
    (pmbusPage == `DCR_PAGE_COMMON && regAddr == `DCR_CMD_NOP) : // R2
    (regAddr == `DCR_ADDR_NOP); // R1

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : gChan
      wire [7:0] page   = (ch == 0) ? `DCR_PAGE_CH0 : `DCR_PAGE_CH1;
      wire [7:0] cfgCmd = (ch == 0) ? `DCR_CMD_CFG_CH0 : `DCR_CMD_CFG_CH1;
      wire [7:0] aMhi   = (ch == 0) ? `DCR_ADDR_CH0_MHI : `DCR_ADDR_CH1_MHI;
      wire [7:0] aMlo   = (ch == 0) ? `DCR_ADDR_CH0_MLO : `DCR_ADDR_CH1_MLO;
      wire [7:0] aCfg   = (ch == 0) ? `DCR_ADDR_CH0_CFG : `DCR_ADDR_CH1_CFG;
      wire [11:0] codeIn;
      wire [2:0]  gainIn;
      wire        cmpLevel;
      wire        pinActive;

      reg [11:0] mhi_reg;
      reg [11:0] mlo_reg;
      reg [2:0]  gain_reg;
      reg [4:0]  ctl_reg;
      reg        res_reg;
      reg        act_reg;
      reg        pinOut_reg;
      reg        pinOe_reg;

      assign selMhi[ch] = pmbusSel ?
        (pmbusPage == page && regAddr == `DCR_CMD_MHI) : // R3
        (regAddr == aMhi);
      assign selMlo[ch] = pmbusSel ?
        (pmbusPage == page && regAddr == `DCR_CMD_MLO) : // R4
        (regAddr == aMlo);
      assign selCfg[ch] = pmbusSel ?
        (pmbusPage == `DCR_PAGE_COMMON && regAddr == cfgCmd) : // R5
        (regAddr == aCfg);

      // Ten-bit parts keep only the upper ten code bits
      assign codeIn = regWData[`DCR_CODE_MSB:`DCR_CODE_LSB] &
        ((TEN_BIT != 0) ? `DCR_CODE_10B_MASK : 12'hfff); // R8
      assign gainIn = regWData[`DCR_GAIN_MSB:`DCR_GAIN_LSB];

      always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          mhi_reg  <= `DCR_CODE_RESET; // R16
          mlo_reg  <= `DCR_CODE_RESET; // R16
          gain_reg <= `DCR_GAIN_RESET; // R16
          ctl_reg  <= 5'h00; // R16
        end else if (regWrite) begin
          if (selMhi[ch])
            mhi_reg <= codeIn; // R6
          if (selMlo[ch])
            mlo_reg <= codeIn; // R7
          if (selCfg[ch]) begin
            // Invalid gain codes keep the old gain, rest still lands
            if (gainIn <= `DCR_GAIN_MAX)
              gain_reg <= gainIn; // R9 R17
            ctl_reg <= regWData[`DCR_OD_BIT:`DCR_EN_BIT]; // R17
          end
        end
      end

      assign mhiWord[ch] = {mhi_reg, 4'h0}; // R17
      assign mloWord[ch] = {mlo_reg, 4'h0}; // R17
      assign cfgWord[ch] = {3'h0, gain_reg, 5'h00, ctl_reg}; // R17

      // Comparator only means anything while enabled
      assign cmpLevel  = cmpRaw[ch] ^ ctl_reg[`DCR_INV_BIT]; // R13
      assign pinActive = ctl_reg[`DCR_EN_BIT] &
                         ctl_reg[`DCR_ROUTE_BIT]; // R11 R14

      always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          res_reg    <= 1'b0;
          act_reg    <= 1'b0;
          pinOut_reg <= 1'b0;
          pinOe_reg  <= 1'b0;
        end else begin
          res_reg <= ctl_reg[`DCR_EN_BIT] & cmpLevel; // R14
          act_reg <= pinActive; // R11
          if (!pinActive) begin
            pinOut_reg <= 1'b0;
            pinOe_reg  <= 1'b0;
          end else if (ctl_reg[`DCR_OD_BIT]) begin
            // Open drain pulls low only, never drives high
            pinOut_reg <= 1'b0; // R10
            pinOe_reg  <= ~cmpLevel; // R10
          end else begin
            pinOut_reg <= cmpLevel; // R10 R11
            pinOe_reg  <= 1'b1;
          end
        end
      end

      assign marginHigh[ch*12 +: 12] = mhi_reg;
      assign marginLow[ch*12 +: 12]  = mlo_reg;
      assign gainSelect[ch*3 +: 3]   = gain_reg;
      assign comparatorModeEnable[ch]      = ctl_reg[`DCR_EN_BIT]; // R14
      assign comparatorPolarityInvert[ch]  = ctl_reg[`DCR_INV_BIT];
      assign feedbackDividerConnect[ch]    = ctl_reg[`DCR_DIV_BIT]; // R12
      assign comparatorPinRoute[ch]        = ctl_reg[`DCR_ROUTE_BIT];
      assign comparatorOpendrainEnable[ch] = ctl_reg[`DCR_OD_BIT];
      assign cmpResult[ch]           = res_reg;
      assign cmpPinActive[ch]        = act_reg;
      assign channelOutputPinOut[ch] = pinOut_reg;
      assign channelOutputPinOe[ch]  = pinOe_reg;
    end
  endgenerate

  reg [15:0] rdMux;
  always @* begin
    rdMux = `DCR_WORD_RESET;
    if (selNop)
      rdMux = `DCR_NOP_VALUE; // R1
    else if (selMhi[0])
      rdMux = mhiWord[0];
    else if (selMhi[1])
      rdMux = mhiWord[1];
    else if (selMlo[0])
      rdMux = mloWord[0];
    else if (selMlo[1])
      rdMux = mloWord[1];
    else if (selCfg[0])
      rdMux = cfgWord[0];
    else if (selCfg[1])
      rdMux = cfgWord[1];
  end

  // Unmapped reads answer zero with regHit low
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRData  <= `DCR_WORD_RESET;
      regRValid <= 1'b0;
      regHit    <= 1'b0;
    end else begin
      regRValid <= regRead;
      regHit    <= (regRead | regWrite) &
                   (selNop | (|selMhi) | (|selMlo) | (|selCfg));
      if (regRead)
        regRData <= rdMux;
    end
  end

endmodule

// ==== hw/dcr_regs.vh ====
`ifndef DCR_REGS_VH
`define DCR_REGS_VH

// Serial (I2C/SPI) register addresses
`define DCR_ADDR_NOP        8'h00
`define DCR_ADDR_CH1_MHI    8'h01
`define DCR_ADDR_CH1_MLO    8'h02
`define DCR_ADDR_CH1_CFG    8'h03
`define DCR_ADDR_CH0_MHI    8'h13
`define DCR_ADDR_CH0_MLO    8'h14
`define DCR_ADDR_CH0_CFG    8'h15

// PMBus pages and command codes
`define DCR_PAGE_COMMON     8'hff
`define DCR_PAGE_CH0        8'h03
`define DCR_PAGE_CH1        8'h00
`define DCR_CMD_NOP         8'hd0
`define DCR_CMD_MHI         8'h25
`define DCR_CMD_MLO         8'h26
`define DCR_CMD_CFG_CH0     8'hdd
`define DCR_CMD_CFG_CH1     8'hd1

// Field layout
`define DCR_WORD_W          16
`define DCR_CODE_W          12
`define DCR_CODE_MSB        15
`define DCR_CODE_LSB        4
`define DCR_CODE_10B_MASK   12'hffc
`define DCR_GAIN_MSB        12
`define DCR_GAIN_LSB        10
`define DCR_GAIN_W          3
`define DCR_GAIN_MAX        3'h5
`define DCR_OD_BIT          4
`define DCR_ROUTE_BIT       3
`define DCR_DIV_BIT         2
`define DCR_INV_BIT         1
`define DCR_EN_BIT          0

// Reset and fixed values
`define DCR_WORD_RESET      16'h0000
`define DCR_CODE_RESET      12'h000
`define DCR_GAIN_RESET      3'h0
`define DCR_NOP_VALUE       16'h0000

`endif

// ==== sim/dcr_checker_sva.sv ====
`timescale 1ns/1ns
module dcr_checker (
  input wire        ref_clk, arst_n, regWrite, regRead, pmbusSel, regHit,
  input wire        regRValid,
  input wire [7:0]  regAddr, pmbusPage,
  input wire [15:0] regWData, regRData,
  input wire [5:0]  gainSelect,
  input wire [1:0]  cmpRaw, cmpResult, comparatorModeEnable, cmpPinActive,
  input wire [1:0]  comparatorPolarityInvert, comparatorOpendrainEnable,
  input wire [1:0]  channelOutputPinOut, channelOutputPinOe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire       acc = regRead | regWrite;
  wire       pmF = acc && pmbusSel && pmbusPage == 8'hff;
  wire       pmC = acc && pmbusSel &&
                   (pmbusPage == 8'h03 || pmbusPage == 8'h00);
  wire [1:0] x   = cmpRaw ^ comparatorPolarityInvert;
  wire       od  = comparatorOpendrainEnable[0];
  sequence s_zero; regRData == 16'h0000; endsequence
  property p_nop; pmF && regRead && regAddr == 8'hd0 |=> s_zero; endproperty
  a_nop: assert property (p_nop) else $error("nop read not zero");
  property p_mhi; pmC && regAddr == 8'h25 |=> regHit; endproperty
  a_mhi: assert property (p_mhi) else $error("margin high miss");
  property p_mlo; pmC && regAddr == 8'h26 |=> regHit; endproperty
  a_mlo: assert property (p_mlo) else $error("margin low miss");
  property p_cfg; pmF && (regAddr == 8'hdd || regAddr == 8'hd1) |=> regHit;
  endproperty
  a_cfg: assert property (p_cfg) else $error("setup miss");
  property p_gain; regWrite && !pmbusSel && regAddr == 8'h15
    && regWData[12:10] > 3'h5 |=> $stable(gainSelect[2:0]); endproperty
  a_gain: assert property (p_gain) else $error("bad gain stored");
  property p_off; !cmpPinActive[0] |-> !channelOutputPinOe[0]; endproperty
  a_off: assert property (p_off) else $error("pin driven unrouted");
  property p_od; cmpPinActive[0] && $past(od) |-> !channelOutputPinOut[0]
    && channelOutputPinOe[0] == !$past(x[0]); endproperty
  a_od: assert property (p_od) else $error("open drain wrong");
  property p_res; cmpResult[0] == $past(x[0] & comparatorModeEnable[0]);
  endproperty
  a_res: assert property (p_res) else $error("result wrong");
  property p_rv; regRead |=> regRValid; endproperty
  a_rv: assert property (p_rv) else $error("read valid missing");
endmodule
bind dcr_channel_config dcr_checker chk (.*);

// ==== sim/dcr_host.sv ====
`timescale 1ns/1ns
module dcr_host (
  input  wire        ref_clk,
  input  wire [15:0] regRData,
  output logic       regWrite, regRead, pmbusSel,
  output logic [7:0] regAddr, pmbusPage,
  output logic [15:0] regWData
);
  initial {regWrite, regRead, pmbusSel, regAddr, pmbusPage, regWData} = '0;
  // Released lines flip so stale values never pass
  task acc(input w, s, input [7:0] p, a, input [15:0] d, output [15:0] q);
    @(posedge ref_clk);
    {regWrite, regRead, pmbusSel} <= {w, !w, s};
    {pmbusPage, regAddr, regWData} <= {p, a, d};
    @(posedge ref_clk);
    {regWrite, regRead} <= 2'b00;
    {pmbusPage, regAddr, regWData} <= ~{p, a, d};
    @(posedge ref_clk);
    q = regRData;
  endtask
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/1ns
module tb;
  logic        ref_clk = 0, arst_n = 0, regWrite, regRead, pmbusSel;
  logic        regRValid, regHit;
  logic [7:0]  regAddr, pmbusPage;
  logic [15:0] regWData, regRData, q;
  logic [23:0] marginHigh, marginLow;
  logic [5:0]  gainSelect;
  logic [1:0]  cmpRaw = 0, comparatorModeEnable, comparatorPinRoute;
  logic [1:0]  comparatorOpendrainEnable, feedbackDividerConnect, cmpResult;
  logic [1:0]  comparatorPolarityInvert, cmpPinActive;
  logic [1:0]  channelOutputPinOut, channelOutputPinOe;
  int          num_errors = 0, checked = 0;
  typedef struct packed {
    logic s; logic [7:0] p, a; logic [15:0] d; logic [7:0] r; logic [15:0] e;
  } dcr_row_t;
  dcr_row_t rows [10] = '{
    '{0, 0, 8'h13, 16'hffff, 8'h13, 16'hfff0}, '{0, 0, 8'h14, 16'h1234, 8'h14,
    16'h1230}, '{0, 0, 8'h15, 16'hffff, 8'h15, 16'h001f}, '{1, 8'h03, 8'h25,
    16'habcd, 8'h13, 16'habc0}, '{1, 0, 8'h25, 16'h5678, 8'h01, 16'h5670},
    '{1, 8'h03, 8'h26, 16'h9abf, 8'h14, 16'h9ab0}, '{1, 0, 8'h26, 16'hffff,
    8'h02, 16'hfff0}, '{1, 8'hff, 8'hdd, 16'h1419, 8'h15, 16'h1419},
    '{1, 8'hff, 8'hd1, 16'h0c1f, 8'h03, 16'h0c1f},
    '{0, 0, 8'h00, 16'hffff, 8'h00, 16'h0000}};
  always #20 ref_clk = ~ref_clk;
  dcr_channel_config dut (.*);
  dcr_host host (.*);
  task chk(input string n, input [23:0] got, exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #100000 num_errors++;
    wrap_up;
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    arst_n <= 1;
    chk("reset", {marginHigh ^ marginLow, gainSelect}, 0);
    $display("reset test done");
    foreach (rows[i]) begin
      host.acc(1, rows[i].s, rows[i].p, rows[i].a, rows[i].d, q);
      host.acc(0, 0, 0, rows[i].r, 0, q);
      chk("readback", q, rows[i].e);
    end
    host.acc(0, 0, 0, 8'h7f, 0, q);
    chk("unmapped", q, 0);
    $display("table test done");
    for (int g = 0; g < 8; g++) begin
      host.acc(1, 0, 0, 8'h15, {3'h0, g[2:0], 10'h000}, q);
      chk("gain", gainSelect[2:0], g < 6 ? g[2:0] : 3'h5);
    end
    // Host has current output off before enabling
    host.acc(1, 0, 0, 8'h15, 16'h001b, q);
    cmpRaw <= 2'b01;
    repeat (2) @(posedge ref_clk);
    chk("drain", {channelOutputPinOe[0], channelOutputPinOut[0]}, 2);
    host.acc(1, 0, 0, 8'h15, 16'h0009, q);
    @(posedge ref_clk);
    chk("push", {channelOutputPinOe[0], channelOutputPinOut[0]}, 3);
    chk("result", cmpResult[0], 1);
    chk("route", {comparatorModeEnable[0], comparatorPinRoute[0]}, 3);
    host.acc(1, 0, 0, 8'h15, 16'h0004, q);
    @(posedge ref_clk);
    chk("divider", {feedbackDividerConnect[0], cmpResult[0]}, 2);
    $display("pin test done");
    arst_n <= 0;
    @(posedge ref_clk);
    chk("rereset", {marginHigh, gainSelect, feedbackDividerConnect}, 0);
    arst_n <= 1;
    $display("second reset test done");
    wrap_up;
  end
endmodule
